// ### rtl/bbhs_pkg.sv
// Package with register map, field layout, reset values and mode states of the sequencer.
package bbhs_pkg;
    localparam int          ADDR_W          = 4;
    localparam int          DATA_W          = 8;
    localparam logic [3:0]  ADDR_STATUS     = 4'h0;
    localparam logic [3:0]  ADDR_MODE       = 4'h8;
    localparam logic [3:0]  ADDR_VOLT       = 4'h9;
    localparam logic [3:0]  ADDR_BATT       = 4'ha;
    localparam logic [3:0]  ADDR_WARN       = 4'hb;
    localparam logic [3:0]  ADDR_STORE      = 4'hc;
    localparam logic [3:0]  ADDR_OPT        = 4'hd;

    // Status bit positions
    localparam int          ST_READY        = 0;
    localparam int          ST_EARLY        = 1;
    localparam int          ST_ALARM        = 2;
    localparam int          ST_LOWBAT       = 3;

    // Mode field, bits 2:0 of mode_control
    localparam int          MODE_LSB        = 0;
    localparam int          MODE_MSB        = 2;
    localparam logic [2:0]  MODE_STANDBY    = 3'h0;
    localparam logic [2:0]  MODE_ONDEMAND   = 3'h1;
    localparam logic [2:0]  MODE_CONTINUOUS = 3'h2;
    localparam logic [2:0]  MODE_ACTIVE     = 3'h4;

    // Early warning enable bit in warning_config
    localparam int          WARN_EN_BIT     = 7;

    localparam logic [7:0]  RST_MODE        = 8'h00;
    localparam logic [7:0]  RST_VOLT        = 8'h00;
    localparam logic [7:0]  RST_BATT        = 8'h00;
    localparam logic [7:0]  RST_WARN        = 8'h00;
    localparam logic [7:0]  RST_STORE       = 8'h00;
    localparam logic [7:0]  RST_OPT         = 8'h00;
    localparam logic [7:0]  READ_ZERO       = 8'h00;

    typedef enum logic [3:0] {
        S_STANDBY   = 4'b0001,
        S_OD_CHARGE = 4'b0010,
        S_CM_CHARGE = 4'b0100,
        S_ACTIVE    = 4'b1000
    } bbhs_state_type;
endpackage : bbhs_pkg

// ### rtl/bbhs_flag_if.sv
// Interface carrying condition inputs and status flags between the sequencer and its flag keeper.
`timescale 1ns/1ns
interface bbhs_flag_if;
    logic isActive;
    logic isRunning;
    logic warnEnable;
    logic standbyEntry;
    logic capNearDepletion;
    logic regulationLost;
    logic batteryLow;
    logic earlyWarning;
    logic alarm;
    logic batteryDepleted;

    modport keeper (
        input  isActive,
        input  isRunning,
        input  warnEnable,
        input  standbyEntry,
        input  capNearDepletion,
        input  regulationLost,
        input  batteryLow,
        output earlyWarning,
        output alarm,
        output batteryDepleted
    );
    modport ctrl (
        output isActive,
        output isRunning,
        output warnEnable,
        output standbyEntry,
        output capNearDepletion,
        output regulationLost,
        output batteryLow,
        input  earlyWarning,
        input  alarm,
        input  batteryDepleted
    );
endinterface : bbhs_flag_if

// ### rtl/bbhs_status_flags.sv
// Status flag keeper: early warning, regulation alarm and battery depleted indications.
`timescale 1ns/1ns
module bbhs_status_flags
    import bbhs_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   rst,
    bbhs_flag_if.keeper flg
);
    logic next_earlyWarning;
    logic next_alarm;
    logic setWarn;
    logic setAlarm;

    // Set wins over the standby clear so a late event is never dropped
    assign setWarn           = flg.warnEnable && flg.isRunning && flg.capNearDepletion;
    assign setAlarm          = flg.isActive && flg.regulationLost;
    assign next_earlyWarning = setWarn || (flg.earlyWarning && !flg.standbyEntry);
    assign next_alarm        = setAlarm || (flg.alarm && !flg.standbyEntry);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flg.earlyWarning    <= 1'b0;
            flg.alarm           <= 1'b0;
            flg.batteryDepleted <= 1'b0;
        end else begin
            flg.earlyWarning    <= next_earlyWarning;
            flg.alarm           <= next_alarm;
            // Advisory only: never stops operation
            flg.batteryDepleted <= flg.batteryLow;
        end
    end
endmodule : bbhs_status_flags

// ### rtl/bbhs_sequencer.sv
// Mode sequencer and register file of the battery booster, device side.
`timescale 1ns/1ns
module bbhs_sequencer
    import bbhs_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              regWrite,
    input  wire logic              regRead,
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [DATA_W-1:0] regWrData,
    output logic      [DATA_W-1:0] regRdData,
    input  wire logic              storeCharged,
    input  wire logic              outputAtSetpoint,
    input  wire logic              capNearDepletion,
    input  wire logic              regulationLost,
    input  wire logic              batteryLow,
    output logic                   readyPin,
    output logic                   chargeEnable,
    output logic                   regulateEnable,
    output logic      [DATA_W-1:0] voltageSetting,
    output logic      [DATA_W-1:0] batteryChargeConfig,
    output logic      [DATA_W-1:0] warningConfig,
    output logic      [DATA_W-1:0] storeLimitConfig,
    output logic      [DATA_W-1:0] optimizerConfig
);
    bbhs_state_type  state;
    bbhs_state_type  next_state;
    logic [DATA_W-1:0] modeControl;
    logic [DATA_W-1:0] statusFlags;
    logic [DATA_W-1:0] next_rdData;
    logic [2:0]        modeField;
    logic              wrMode;
    logic              wrVolt;
    logic              wrBatt;
    logic              wrWarn;
    logic              wrStore;
    logic              wrOpt;
    logic              cmdStandby;
    logic              cmdOnDemand;
    logic              cmdContinuous;
    logic              cmdActive;
    logic              readyLevel;
    logic              next_ready;
    logic              next_chargeEnable;
    logic              next_regulateEnable;
    logic              activeAtSetpoint;
    logic              contStoreFull;

    bbhs_flag_if flagBus ();

    bbhs_status_flags u_flags (
        .clk (clk),
        .rst (rst),
        .flg (flagBus.keeper)
    );

    // Address decode
    assign wrMode  = regWrite && (regAddr == ADDR_MODE);
    assign wrVolt  = regWrite && (regAddr == ADDR_VOLT);
    assign wrBatt  = regWrite && (regAddr == ADDR_BATT);
    assign wrWarn  = regWrite && (regAddr == ADDR_WARN);
    assign wrStore = regWrite && (regAddr == ADDR_STORE);
    assign wrOpt   = regWrite && (regAddr == ADDR_OPT);

    assign modeField     = regWrData[MODE_MSB:MODE_LSB];
    assign cmdStandby    = wrMode && (modeField == MODE_STANDBY);
    assign cmdOnDemand   = wrMode && (modeField == MODE_ONDEMAND);
    assign cmdContinuous = wrMode && (modeField == MODE_CONTINUOUS);
    assign cmdActive     = wrMode && (modeField == MODE_ACTIVE);

    // Mode sequencing; unsupported mode codes leave the state alone
    always_comb begin
        next_state = state;
        case (state)
            S_STANDBY: begin
                if (cmdOnDemand) begin
                    next_state = S_OD_CHARGE;
                end else if (cmdContinuous) begin
                    next_state = S_CM_CHARGE;
                end
            end
            S_OD_CHARGE: begin
                if (cmdStandby) begin
                    next_state = S_STANDBY;
                end else if (storeCharged) begin
                    next_state = S_ACTIVE;
                end
            end
            S_CM_CHARGE: begin
                if (cmdStandby) begin
                    next_state = S_STANDBY;
                end else if (cmdActive && storeCharged) begin
                    next_state = S_ACTIVE;
                end
            end
            S_ACTIVE: begin
                if (cmdStandby) begin
                    next_state = S_STANDBY;
                end else if (cmdContinuous) begin
                    next_state = S_CM_CHARGE;
                end
            end
            default: begin
                next_state = S_STANDBY;
            end
        endcase
    end

    assign flagBus.isActive         = (state == S_ACTIVE);
    assign flagBus.isRunning        = (state != S_STANDBY);
    assign flagBus.warnEnable       = warningConfig[WARN_EN_BIT];
    assign flagBus.standbyEntry     = cmdStandby;
    assign flagBus.capNearDepletion = capNearDepletion;
    assign flagBus.regulationLost   = regulationLost;
    assign flagBus.batteryLow       = batteryLow;

    // Continuous mode reports ready once storage is charged so host may go active
    assign activeAtSetpoint = (state == S_ACTIVE) && outputAtSetpoint;
    assign contStoreFull    = (state == S_CM_CHARGE) && storeCharged;
    assign readyLevel       = activeAtSetpoint || contStoreFull;
    // Early warning pulls the ready pin low so a pin watcher sees it without polling
    assign next_ready = readyLevel && !flagBus.earlyWarning;

    // Enables follow the next state so converter and state register never disagree
    assign next_chargeEnable   = (next_state == S_OD_CHARGE) || (next_state == S_CM_CHARGE);
    assign next_regulateEnable = (next_state == S_ACTIVE);

    always_comb begin
        statusFlags             = READ_ZERO;
        statusFlags[ST_READY]   = readyPin;
        statusFlags[ST_EARLY]   = flagBus.earlyWarning;
        statusFlags[ST_ALARM]   = flagBus.alarm;
        statusFlags[ST_LOWBAT]  = flagBus.batteryDepleted;
    end

    always_comb begin
        if (!regRead) begin
            next_rdData = READ_ZERO;
        end else if (regAddr == ADDR_STATUS) begin
            next_rdData = statusFlags;
        end else if (regAddr == ADDR_MODE) begin
            next_rdData = modeControl;
        end else if (regAddr == ADDR_VOLT) begin
            next_rdData = voltageSetting;
        end else if (regAddr == ADDR_BATT) begin
            next_rdData = batteryChargeConfig;
        end else if (regAddr == ADDR_WARN) begin
            next_rdData = warningConfig;
        end else if (regAddr == ADDR_STORE) begin
            next_rdData = storeLimitConfig;
        end else if (regAddr == ADDR_OPT) begin
            next_rdData = optimizerConfig;
        end else begin
            next_rdData = READ_ZERO;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state          <= S_STANDBY;
            readyPin       <= 1'b0;
            chargeEnable   <= 1'b0;
            regulateEnable <= 1'b0;
        end else begin
            state          <= next_state;
            readyPin       <= next_ready;
            chargeEnable   <= next_chargeEnable;
            regulateEnable <= next_regulateEnable;
        end
    end

    // Read data falls back to zero after one cycle so a stale answer never looks fresh
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regRdData <= READ_ZERO;
        end else begin
            regRdData <= next_rdData;
        end
    end

    // Configuration registers feed the converter; setpoint and fixed voltage in voltage_setting
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            modeControl         <= RST_MODE;
            voltageSetting      <= RST_VOLT;
            batteryChargeConfig <= RST_BATT;
            warningConfig       <= RST_WARN;
            storeLimitConfig    <= RST_STORE;
            optimizerConfig     <= RST_OPT;
        end else begin
            if (wrMode) begin
                // Whole byte kept even when the transition is refused, so readback shows the last command
                modeControl <= regWrData;
            end
            if (wrVolt) begin
                voltageSetting <= regWrData;
            end
            if (wrBatt) begin
                batteryChargeConfig <= regWrData;
            end
            if (wrWarn) begin
                warningConfig <= regWrData;
            end
            if (wrStore) begin
                storeLimitConfig <= regWrData;
            end
            if (wrOpt) begin
                optimizerConfig <= regWrData;
            end
        end
    end
endmodule : bbhs_sequencer

// ### bench/bbhs_sequencer_sva.sv
// Port-level assertions for the battery booster sequencer.
`timescale 1ns/1ns
module bbhs_sequencer_sva
    import bbhs_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              regWrite,
    input wire logic              regRead,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic [DATA_W-1:0] regRdData,
    input wire logic              storeCharged,
    input wire logic              outputAtSetpoint,
    input wire logic              capNearDepletion,
    input wire logic              regulationLost,
    input wire logic              batteryLow,
    input wire logic              readyPin,
    input wire logic              chargeEnable,
    input wire logic              regulateEnable,
    input wire logic [DATA_W-1:0] warningConfig
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire statusRd  = regRead && regAddr == ADDR_STATUS;
    wire modeWr    = regWrite && regAddr == ADDR_MODE;
    wire activeWr  = modeWr && regWrData[2:0] == MODE_ACTIVE;
    wire standbyWr = modeWr && regWrData[2:0] == MODE_STANDBY;
    // A mode write in between may clear the sticky flags, so the windows demand a quiet bus
    sequence loss_then_read;
        regulateEnable && regulationLost ##1 !regWrite ##1 statusRd && !regWrite;
    endsequence
    sequence warn_then_quiet;
        warningConfig[WARN_EN_BIT] && capNearDepletion && (chargeEnable || regulateEnable) ##1 !regWrite;
    endsequence
    a_ready_cause: assert property (readyPin |-> $past(regulateEnable && outputAtSetpoint || chargeEnable && storeCharged))
        else $error("ready raised without a cause");
    a_status_mirror: assert property (statusRd |=> regRdData[ST_READY] == $past(readyPin) && regRdData[7:4] == 4'h0)
        else $error("status read does not mirror ready");
    a_warn_drops_ready: assert property (warn_then_quiet |=> !readyPin)
        else $error("ready stayed high under early warning");
    a_alarm_sticks: assert property (loss_then_read |=> regRdData[ST_ALARM])
        else $error("alarm flag missing after regulation loss");
    a_lowbat_shown: assert property (statusRd && batteryLow && $past(batteryLow && !rst) |=> regRdData[ST_LOWBAT])
        else $error("battery depleted flag missing");
    a_active_entry: assert property (activeWr && chargeEnable && storeCharged |=> regulateEnable)
        else $error("active state not entered");
    a_standby_entry: assert property (standbyWr |=> !chargeEnable && !regulateEnable ##1 !readyPin)
        else $error("standby write did not stop the device");
endmodule : bbhs_sequencer_sva

bind bbhs_sequencer bbhs_sequencer_sva u_bbhs_sequencer_sva (
    .clk, .rst, .regWrite, .regRead, .regAddr, .regWrData, .regRdData, .storeCharged, .outputAtSetpoint,
    .capNearDepletion, .regulationLost, .batteryLow, .readyPin, .chargeEnable, .regulateEnable, .warningConfig
);

// ### bench/bbhs_host.sv
// Host model driving the sequencer register strobe port.
`timescale 1ns/1ns
module bbhs_host
    import bbhs_pkg::*;
#(
    parameter int STARTUP_CYCLES = 50
)(
    input  wire logic              clk,
    output logic                   regWrite,
    output logic                   regRead,
    output logic      [ADDR_W-1:0] regAddr,
    output logic      [DATA_W-1:0] regWrData,
    input  wire logic [DATA_W-1:0] regRdData
);
    initial begin
        regWrite  = 1'b0;
        regRead   = 1'b0;
        regAddr   = 4'h0;
        regWrData = 8'h00;
    end
    // Released address and data lines show the inverse of the last value, strobes drop to zero, so stale data is never trusted
    task automatic access(input logic wr, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        regWrite  <= wr;
        regRead   <= !wr;
        regAddr   <= a;
        regWrData <= d;
        @(posedge clk);
        regWrite  <= 1'b0;
        regRead   <= 1'b0;
        regAddr   <= ~a;
        regWrData <= ~d;
        @(posedge clk);
        q = regRdData;
    endtask : access
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] q;
        access(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] q);
        access(1'b0, a, 8'h00, q);
    endtask : rd
    task automatic settle();
        repeat (STARTUP_CYCLES) @(posedge clk);
    endtask : settle
    task automatic start(input logic [2:0] mode, input logic [7:0] volt);
        wr(ADDR_VOLT, volt);
        wr(ADDR_MODE, {5'h00, mode});
    endtask : start
    task automatic stop();
        wr(ADDR_MODE, {5'h00, MODE_STANDBY});
    endtask : stop
endmodule : bbhs_host

// ### bench/tb.sv
// Self-checking testbench for the battery booster sequencer.
`timescale 1ns/1ns
module tb;
    import bbhs_pkg::*;
    logic              clk, rst, regWrite, regRead, readyPin, chargeEnable, regulateEnable;
    logic              storeCharged, outputAtSetpoint, capNearDepletion, regulationLost, batteryLow;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWrData, regRdData, voltageSetting, batteryChargeConfig;
    logic [DATA_W-1:0] warningConfig, storeLimitConfig, optimizerConfig, q, d;
    logic [DATA_W-1:0] cfg [8];
    int                failures, n_checks, cycles;
    localparam logic [3:0] ADDRS [8] = '{ADDR_STATUS, ADDR_MODE, ADDR_VOLT, ADDR_BATT, ADDR_WARN, ADDR_STORE,
                                         ADDR_OPT, 4'h3};
    localparam logic [7:0] RSTV [8] = '{8'h00, RST_MODE, RST_VOLT, RST_BATT, RST_WARN, RST_STORE, RST_OPT, READ_ZERO};

    bbhs_sequencer u_bbhs_sequencer (
        .clk, .rst, .regWrite, .regRead, .regAddr, .regWrData, .regRdData, .storeCharged, .outputAtSetpoint,
        .capNearDepletion, .regulationLost, .batteryLow, .readyPin, .chargeEnable, .regulateEnable,
        .voltageSetting, .batteryChargeConfig, .warningConfig, .storeLimitConfig, .optimizerConfig
    );
    bbhs_host #(.STARTUP_CYCLES(50)) u_bbhs_host (.clk, .regWrite, .regRead, .regAddr, .regWrData, .regRdData);

    function automatic logic [7:0] status_of(input logic rdy, input logic ew, input logic al, input logic lb);
        return {4'h0, lb, al, ew, rdy};
    endfunction : status_of
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_ready();
        for (int i = 0; i < 40 && readyPin !== 1'b1; i++) @(posedge clk);
    endtask : wait_ready
    task automatic complete_run();
        if (failures == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Whole sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            complete_run();
        end
    end

    initial begin
        rst = 1'b1;
        {storeCharged, outputAtSetpoint, capNearDepletion, regulationLost, batteryLow} = 5'h00;
        void'($urandom(54381));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        u_bbhs_host.settle();
        for (int i = 0; i < 8; i++) begin
            u_bbhs_host.rd(ADDRS[i], q);
            chk(q, RSTV[i]);
        end
        for (int i = 2; i < 7; i++) begin
            cfg[i] = 8'($urandom);
            u_bbhs_host.wr(ADDRS[i], cfg[i]);
            u_bbhs_host.rd(ADDRS[i], q);
            chk(q, cfg[i]);
        end
        chk({voltageSetting, batteryChargeConfig, warningConfig, storeLimitConfig, optimizerConfig},
            {cfg[2], cfg[3], cfg[4], cfg[5], cfg[6]});
        u_bbhs_host.wr(ADDR_STATUS, 8'hff);
        u_bbhs_host.rd(ADDR_STATUS, q);
        chk(q, status_of(1'b0, 1'b0, 1'b0, 1'b0));
        d = 8'($urandom);
        u_bbhs_host.start(MODE_ONDEMAND, d);
        chk({chargeEnable, regulateEnable, readyPin}, 3'b100);
        storeCharged <= 1'b1;
        outputAtSetpoint <= 1'b1;
        wait_ready();
        chk({readyPin, regulateEnable}, 2'b11);
        batteryLow <= 1'b1;
        u_bbhs_host.rd(ADDR_STATUS, q);
        chk(q, status_of(1'b1, 1'b0, 1'b0, 1'b1));
        regulationLost <= 1'b1;
        @(posedge clk);
        regulationLost <= 1'b0;
        u_bbhs_host.rd(ADDR_STATUS, q);
        chk(q, status_of(1'b1, 1'b0, 1'b1, 1'b1));
        chk(regulateEnable, 1'b1);
        batteryLow <= 1'b0;
        u_bbhs_host.stop();
        u_bbhs_host.rd(ADDR_STATUS, q);
        chk({chargeEnable, regulateEnable, q}, {2'b00, status_of(1'b0, 1'b0, 1'b0, 1'b0)});
        storeCharged <= 1'b0;
        u_bbhs_host.start(MODE_CONTINUOUS, d);
        u_bbhs_host.wr(ADDR_MODE, {5'h00, MODE_ACTIVE});
        chk({chargeEnable, regulateEnable}, 2'b10);
        storeCharged <= 1'b1;
        wait_ready();
        u_bbhs_host.wr(ADDR_MODE, {5'h00, MODE_ACTIVE});
        chk({chargeEnable, regulateEnable}, 2'b01);
        u_bbhs_host.wr(ADDR_MODE, {5'h00, MODE_CONTINUOUS});
        chk({chargeEnable, regulateEnable}, 2'b10);
        u_bbhs_host.wr(ADDR_WARN, 8'(1) << WARN_EN_BIT);
        capNearDepletion <= 1'b1;
        @(posedge clk);
        u_bbhs_host.rd(ADDR_STATUS, q);
        chk({readyPin, q}, {1'b0, status_of(1'b0, 1'b1, 1'b0, 1'b0)});
        capNearDepletion <= 1'b0;
        u_bbhs_host.stop();
        u_bbhs_host.rd(ADDR_STATUS, q);
        chk(q, status_of(1'b0, 1'b0, 1'b0, 1'b0));
        u_bbhs_host.rd(ADDR_MODE, q);
        chk(q, {5'h00, MODE_STANDBY});
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({voltageSetting, batteryChargeConfig, warningConfig, storeLimitConfig, optimizerConfig},
            {RST_VOLT, RST_BATT, RST_WARN, RST_STORE, RST_OPT});
        complete_run();
    end
endmodule : tb
